// >>> logic/ddsl_pkg.sv
// Package: constants and carrier types for the dual converter serial front end
`default_nettype none
package ddsl_pkg;
	localparam int WORD_W = 16;
	localparam int CODE_W = 14;
	localparam int ADDR_HI_POS = 15;
	localparam int ADDR_LO_POS = 14;
	localparam logic [CODE_W-1:0] CODE_ZERO = 14'h0000;
	localparam logic [CODE_W-1:0] CODE_MID = 14'h2000;
	localparam logic [CODE_W-1:0] CODE_FULL = 14'h3fff;
	localparam logic [1:0] ADDR_CHAN_A = 2'h0;
	localparam logic [1:0] ADDR_CHAN_B = 2'h1;
	localparam logic [WORD_W-1:0] SHIFT_RESET = 16'h0000;
	// Synchroniser reset values match the idle pin levels
	localparam logic [2:0] LINK_SYNC_RESET = 3'h4;
	localparam logic [2:0] MISC_SYNC_RESET = 3'h6;

	// Link pin group sampled from the host
	typedef struct packed {
		logic chip_sel_n;
		logic serial_in;
		logic sclk;
	} ddsl_link_s;

	// Pair of 14-bit codes, one per channel
	typedef struct packed {
		logic [CODE_W-1:0] chan_b;
		logic [CODE_W-1:0] chan_a;
	} ddsl_pair_s;

	// Preset sequencer states, gray along reset path
	typedef enum logic [1:0] {
		DDSL_SYNC0 = 2'h0,
		DDSL_SYNC1 = 2'h1,
		DDSL_PRESET = 2'h3,
		DDSL_RUN = 2'h2
	} ddsl_state_e;
endpackage : ddsl_pkg
`default_nettype wire

// >>> logic/ddsl_core.sv
// Module: serial load, input and converter registers of a dual converter
`default_nettype none
module ddsl_core
	import ddsl_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CHIP_SEL_N,
	input wire logic SERIAL_IN,
	input wire logic SCLK,
	input wire logic LOAD_STROBE_N,
	input wire logic PRESET_N,
	input wire logic MIDSCALE_SEL,
	output logic [CODE_W-1:0] DAC_A,
	output logic [CODE_W-1:0] DAC_B,
	output logic [CODE_W-1:0] INPUT_A,
	output logic [CODE_W-1:0] INPUT_B
);
	// Two-flop synchronisers for all outside pins except RST_B
	logic [2:0] link_s1_q;
	logic [2:0] link_s2_q;
	logic [2:0] link_s3_q;
	logic [2:0] misc_s1_q;
	logic [2:0] misc_s2_q;
	ddsl_link_s link_now;
	ddsl_link_s link_old;
	ddsl_link_s link_raw;

	assign link_raw = '{chip_sel_n: CHIP_SEL_N, serial_in: SERIAL_IN,
		sclk: SCLK};

	// Idle-level reset values: no false select or strobe edge
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			link_s1_q <= LINK_SYNC_RESET;
			link_s2_q <= LINK_SYNC_RESET;
			link_s3_q <= LINK_SYNC_RESET;
			misc_s1_q <= MISC_SYNC_RESET;
			misc_s2_q <= MISC_SYNC_RESET;
		end else begin
			link_s1_q <= link_raw;
			link_s2_q <= link_s1_q;
			link_s3_q <= link_s2_q;
			misc_s1_q <= {LOAD_STROBE_N, PRESET_N, MIDSCALE_SEL};
			misc_s2_q <= misc_s1_q;
		end
	end

	// Edge decode on synchronised link
	assign link_now = link_s2_q;
	assign link_old = link_s3_q;
	wire logic sclk_rise = link_now.sclk & ~link_old.sclk;
	wire logic selected = ~link_now.chip_sel_n;
	wire logic shift_en = sclk_rise & selected;
	wire logic cs_rise = link_now.chip_sel_n & ~link_old.chip_sel_n;
	wire logic load_n_s = misc_s2_q[2];
	wire logic preset_n_s = misc_s2_q[1];
	wire logic mid_s = misc_s2_q[0];

	// Preset sequencer: waits until strap crosses both flops
	ddsl_state_e state_q;
	ddsl_state_e state_d;
	logic [CODE_W-1:0] preset_val;
	assign preset_val = mid_s ? CODE_MID : CODE_ZERO;
	wire logic do_preset = (state_q != DDSL_RUN) | ~preset_n_s;

	always_comb begin
		case (state_q)
			DDSL_SYNC0: state_d = DDSL_SYNC1;
			DDSL_SYNC1: state_d = DDSL_PRESET;
			DDSL_PRESET: state_d = DDSL_RUN;
			DDSL_RUN: state_d = DDSL_RUN;
			default: state_d = DDSL_PRESET;
		endcase
	end

	// Shift register, MSB first
	logic [WORD_W-1:0] shift_q;
	logic [WORD_W-1:0] shift_d;
	assign shift_d = shift_en ? {shift_q[WORD_W-2:0], link_now.serial_in}
		: shift_q;

	// Word decode: address pair and code field
	wire logic [1:0] addr = {shift_q[ADDR_HI_POS], shift_q[ADDR_LO_POS]};
	wire logic [CODE_W-1:0] code_bits = shift_q[CODE_W-1:0];
	wire logic wr_a = cs_rise & (addr == ADDR_CHAN_A);
	wire logic wr_b = cs_rise & (addr == ADDR_CHAN_B);

	ddsl_pair_s in_q;
	ddsl_pair_s in_d;
	ddsl_pair_s dac_q;
	ddsl_pair_s dac_d;

	// Input register next values
	always_comb begin
		in_d = in_q;
		if (do_preset) begin
			in_d = '{chan_b: preset_val, chan_a: preset_val};
		end else begin
			if (wr_a) begin
				in_d.chan_a = code_bits;
			end
			if (wr_b) begin
				in_d.chan_b = code_bits;
			end
		end
	end

	// Converter registers: transparent while strobe low
	always_comb begin
		if (do_preset) begin
			dac_d = '{chan_b: preset_val, chan_a: preset_val};
		end else if (!load_n_s) begin
			dac_d = in_d;
		end else begin
			dac_d = dac_q;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= DDSL_SYNC0;
			shift_q <= SHIFT_RESET;
			in_q <= '0;
			dac_q <= '0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			in_q <= in_d;
			dac_q <= dac_d;
		end
	end

	// Outputs straight from registers
	assign DAC_A = dac_q.chan_a;
	assign DAC_B = dac_q.chan_b;
	assign INPUT_A = in_q.chan_a;
	assign INPUT_B = in_q.chan_b;

	// Checks
	a_shift_hold: assert property (@(posedge CLK) disable iff (!RST_B)
		!shift_en |=> $stable(shift_q))
		else $error("shift register moved without selected sclk rise");
	a_shift_bit: assert property (@(posedge CLK) disable iff (!RST_B)
		shift_en |=> shift_q[0] == $past(link_now.serial_in))
		else $error("shifted bit does not match serial input");
	a_write_a: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_a && !do_preset |=> in_q.chan_a == $past(code_bits))
		else $error("channel A input not loaded on select release");
	a_write_b: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_b && !do_preset |=> in_q.chan_b == $past(code_bits))
		else $error("channel B input not loaded on select release");
	a_no_target: assert property (@(posedge CLK) disable iff (!RST_B)
		cs_rise && addr[1] && !do_preset |=> $stable(in_q))
		else $error("unused address changed an input register");
	a_load_pass: assert property (@(posedge CLK) disable iff (!RST_B)
		!load_n_s && !do_preset ##1 !do_preset |-> dac_q == in_q)
		else $error("converter registers not following inputs");
	a_load_hold: assert property (@(posedge CLK) disable iff (!RST_B)
		load_n_s && !do_preset |=> $stable(dac_q))
		else $error("converter registers changed with strobe high");
	a_preset_val: assert property (@(posedge CLK) disable iff (!RST_B)
		!preset_n_s |=> dac_q.chan_a == $past(preset_val)
		&& in_q.chan_b == $past(preset_val))
		else $error("preset value wrong");
	a_power_on: assert property (@(posedge CLK) disable iff (!RST_B)
		state_q == DDSL_PRESET |=> dac_q.chan_b == $past(preset_val))
		else $error("power-on preset value wrong");
	c_write_a: cover property (@(posedge CLK) disable iff (!RST_B) wr_a);
	c_write_b: cover property (@(posedge CLK) disable iff (!RST_B) wr_b);
	c_full: cover property (@(posedge CLK) disable iff (!RST_B)
		dac_q.chan_a == CODE_FULL);
	c_preset_mid: cover property (@(posedge CLK) disable iff (!RST_B)
		!preset_n_s && mid_s);
	c_power_mid: cover property (@(posedge CLK) disable iff (!RST_B)
		state_q == DDSL_PRESET && mid_s);

	// Further transfer and sequencer checks
	a_cs_high_hold: assert property (@(posedge CLK) disable iff (!RST_B)
		link_now.chip_sel_n |=> $stable(shift_q))
		else $error("shift register moved while deselected");
	a_no_stray_write: assert property (@(posedge CLK) disable iff (!RST_B)
		!cs_rise && !do_preset |=> $stable(in_q))
		else $error("input register changed without select release");
	a_write_a_only: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_a && !do_preset |=> $stable(in_q.chan_b))
		else $error("channel A write disturbed channel B");
	a_write_b_only: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_b && !do_preset |=> $stable(in_q.chan_a))
		else $error("channel B write disturbed channel A");
	a_load_code: assert property (@(posedge CLK) disable iff (!RST_B)
		!load_n_s && !do_preset |=> dac_q == $past(in_d))
		else $error("converter registers not following with strobe low");
	a_preset_all: assert property (@(posedge CLK) disable iff (!RST_B)
		!preset_n_s |=> in_q.chan_a == $past(preset_val)
		&& dac_q.chan_b == $past(preset_val))
		else $error("preset missed a register");
	a_power_done: assert property (@(posedge CLK) disable iff (!RST_B)
		state_q == DDSL_SYNC0 |-> ##3 state_q == DDSL_RUN)
		else $error("power-on sequencer did not reach run");
	a_strap_used: assert property (@(posedge CLK) disable iff (!RST_B)
		state_q == DDSL_PRESET |=> in_q.chan_a == $past(preset_val))
		else $error("power-on input preset wrong");
	a_mid_code: assert property (@(posedge CLK) disable iff (!RST_B)
		state_q == DDSL_PRESET && mid_s |=> dac_q.chan_a == CODE_MID)
		else $error("power-on midscale code wrong");
endmodule : ddsl_core
`default_nettype wire

// >>> verification/ddsl_host.sv
// Host serial master model for the converter link
`default_nettype none
module ddsl_host (
	output logic CHIP_SEL_N,
	output logic SERIAL_IN,
	output logic SCLK
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle link: deselected, clock parked low
	initial begin
		CHIP_SEL_N = 1'b1;
		SERIAL_IN = 1'b0;
		SCLK = 1'b0;
	end
	// Send n bits MSB first; sel low clocks with select high
	task automatic send(input logic [23:0] w, input int n, input logic sel);
		CHIP_SEL_N = ~sel;
		for (int i = n - 1; i >= 0; i--) begin
			SERIAL_IN = w[i];
			#62.5 SCLK = 1'b1;
			#62.5 SCLK = 1'b0;
		end
		#62.5 CHIP_SEL_N = 1'b1;
		SERIAL_IN = ~SERIAL_IN; // Released line, stale value inverted
		#62.5;
	endtask : send
endmodule : ddsl_host
`default_nettype wire

// >>> verification/test_dual_dac_serial_load_logic.sv
// Self-checking bench for the converter serial front end
`default_nettype none
module test_dual_dac_serial_load_logic
	import ddsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK = 1'b0, RST_B = 1'b0, LOAD_STROBE_N = 1'b1;
	logic PRESET_N = 1'b1, MIDSCALE_SEL = 1'b1;
	logic CHIP_SEL_N, SERIAL_IN, SCLK;
	logic [CODE_W-1:0] DAC_A, DAC_B, INPUT_A, INPUT_B;
	int errors = 0, checks_done = 0;
	// Clock and instances
	always #5 CLK = ~CLK;
	ddsl_host host_u (.CHIP_SEL_N, .SERIAL_IN, .SCLK);
	ddsl_core dut_u (.CLK, .RST_B, .CHIP_SEL_N, .SERIAL_IN, .SCLK,
		.LOAD_STROBE_N, .PRESET_N, .MIDSCALE_SEL, .DAC_A, .DAC_B,
		.INPUT_A, .INPUT_B);
	task automatic chk(input logic [CODE_W-1:0] s, e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
	endtask : wt
	// Compare away from the edge that launched the outputs
	task automatic look();
		@(negedge CLK);
	endtask : look
	// Preset pin under both strap values
	task automatic t_preset();
		for (int m = 0; m < 2; m++) begin
			MIDSCALE_SEL <= m[0];
			wt(3);
			PRESET_N <= 1'b0;
			wt(6);
			PRESET_N <= 1'b1;
			wt(4);
			look();
			chk(INPUT_A, m ? CODE_MID : CODE_ZERO);
			chk(DAC_B, m ? CODE_MID : CODE_ZERO);
			wt(1);
		end
		$display("preset test done");
	endtask : t_preset
	// Writes with strobe high: extra bits, bad address, idle clocks
	task automatic t_write();
		host_u.send(24'hc0_0abc, 24, 1'b1);
		wt(8);
		look();
		chk(INPUT_A, 14'h0abc);
		chk(DAC_A, CODE_MID);
		host_u.send(16'h7fff, 16, 1'b1);
		wt(8);
		look();
		chk(INPUT_B, CODE_FULL);
		host_u.send(16'hb555, 16, 1'b1);
		wt(8);
		look();
		chk(INPUT_B, CODE_FULL);
		chk(INPUT_A, 14'h0abc);
		host_u.send(16'h0111, 16, 1'b0);
		host_u.send(24'h12, 8, 1'b1);
		wt(8);
		look();
		chk(INPUT_B, 14'h1512);
		chk(INPUT_A, 14'h0abc);
		$display("write test done");
	endtask : t_write
	// Strobe copies both, outputs follow, then hold again
	task automatic t_strobe();
		wt(1);
		LOAD_STROBE_N <= 1'b0;
		wt(6);
		look();
		chk(DAC_A, 14'h0abc);
		chk(DAC_B, 14'h1512);
		host_u.send(16'h0123, 16, 1'b1);
		wt(8);
		look();
		chk(DAC_A, 14'h0123);
		wt(1);
		LOAD_STROBE_N <= 1'b1;
		wt(4);
		host_u.send(16'h0001, 16, 1'b1);
		wt(8);
		look();
		chk(INPUT_A, 14'h0001);
		chk(DAC_A, 14'h0123);
		$display("strobe test done");
	endtask : t_strobe
	// Mid-run reset with the midscale strap still set
	task automatic t_reset();
		wt(1);
		RST_B <= 1'b0;
		wt(3);
		RST_B <= 1'b1;
		wt(3);
		look();
		chk(INPUT_A, CODE_MID);
		chk(DAC_B, CODE_MID);
		$display("reset test done");
	endtask : t_reset
	// Main sequence
	initial begin
		wt(10);
		RST_B <= 1'b1;
		wt(3);
		look();
		chk(DAC_A, CODE_MID);
		chk(INPUT_B, CODE_MID);
		wt(4);
		t_preset();
		t_write();
		t_strobe();
		t_reset();
		final_report();
	end
	// Watchdog
	initial begin
		#200us;
		errors++;
		final_report();
	end
endmodule : test_dual_dac_serial_load_logic
`default_nettype wire
